// >>> design/tce_top.sv
`timescale 1ns/1ps
// Behaviour
// R1 - 24-bit enable register at 28h, resets zero
// R2 - pair code: none, rising, falling, both
// R3 - bits 23-20: supply one-A low, one-B high
// R4 - bits 19-16: supply zero-A low, zero-B high
// R5 - bits 15-6: pairs A, B, C lowest
// R6 - fourth pair threshold eight, fifth nine
// R7 - bits 5-0: group-three A, B, C
// R8 - all fields read back last written value
// R9 - thresholds eight and nine are 10 bits
// R10 - crossing from previous vs new sample, gated
module tce_top (
  input wire logic clk_in,                       // 20 MHz clock
  input wire logic reset_n_in,                   // async reset
  input wire tce_pkg::tce_req_t req_in,          // register request
  input wire tce_pkg::tce_thr_t thr_in,          // threshold values
  input wire tce_pkg::tce_smp_t supply_in,       // supply sample
  input wire tce_pkg::tce_smp_t switch_input_twentytwo_in,         // input 22 sample
  input wire tce_pkg::tce_smp_t switch_input_twentythree_in,         // input 23 sample
  output logic [23:0] rdata_out,                 // read data
  output logic rvalid_out,                       // read data valid
  output logic [23:0] enable_out,                // enable register
  output logic [11:0] event_out                  // crossing events
);
  // ****************************************************
  // reset release
  // ****************************************************
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ****************************************************
  // register port
  // ****************************************************
  logic [23:0] en_q;
  logic [23:0] en_d;
  logic [23:0] rdata_q;
  logic [23:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic hit;

  always_comb begin
    hit = req_in.addr == tce_pkg::TCE_ENABLE_BANK4_OFFSET; // R1
    en_d = en_q;
    if (req_in.wr && hit) begin
      en_d = req_in.wdata; // R8
    end
    rvalid_d = req_in.rd;
    rdata_d = 24'h00_0000;
    if (req_in.rd && hit) begin
      rdata_d = en_q; // R8
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_q <= tce_pkg::TCE_ENABLE_BANK4_RESET; // R1
      rdata_q <= 24'h00_0000;
      rvalid_q <= 1'b0;
    end else begin
      en_q <= en_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************************
  // crossing detectors
  // ****************************************************
  logic [11:0] smp_vld;
  logic [9:0] smp_val [12];
  logic [9:0] thr_val [12];
  logic [11:0] evt;
  logic [11:0] evt_q;
  logic [11:0] evt_d;

  always_comb begin
    smp_vld = {{4{supply_in.valid}}, {5{switch_input_twentythree_in.valid}},
               {3{switch_input_twentytwo_in.valid}}};
    for (int i = 0; i < 12; i++) begin
      smp_val[i] = supply_in.value;
    end
    for (int i = tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTWO_A; i <= tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTWO_C; i++) begin
      smp_val[i] = switch_input_twentytwo_in.value; // R7
    end
    for (int i = tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTHREE_A; i <= tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTHREE_NINE;
         i++) begin
      smp_val[i] = switch_input_twentythree_in.value; // R5
    end
    thr_val[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTWO_A] = thr_in.group_three_threshold_a; // R7
    thr_val[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTWO_B] = thr_in.group_three_threshold_b;
    thr_val[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTWO_C] = thr_in.group_three_threshold_c;
    thr_val[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTHREE_A] = thr_in.group_three_threshold_a; // R5
    thr_val[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTHREE_B] = thr_in.group_three_threshold_b;
    thr_val[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTHREE_C] = thr_in.group_three_threshold_c;
    thr_val[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTHREE_EIGHT] = thr_in.threshold_eight; // R6 R9
    thr_val[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTHREE_NINE] = thr_in.threshold_nine; // R6 R9
    thr_val[tce_pkg::TCE_X_SUP0_A] = thr_in.supply_threshold_zero_a; // R4
    thr_val[tce_pkg::TCE_X_SUP0_B] = thr_in.supply_threshold_zero_b; // R4
    thr_val[tce_pkg::TCE_X_SUP1_A] = thr_in.supply_threshold_one_a; // R3
    thr_val[tce_pkg::TCE_X_SUP1_B] = thr_in.supply_threshold_one_b; // R3
    evt_d = evt;
  end

  // pair i of the register steers crossing i
  for (genvar g = 0; g < tce_pkg::TCE_CROSSINGS; g++) begin : g_cross
    tce_cross #(
      .W(tce_pkg::TCE_SAMPLE_WIDTH)
    ) u_cross (
      .clk_in(clk_in),
      .rst_n_in(rst_n_q),
      .sample_valid_in(smp_vld[g]),
      .sample_in(smp_val[g]),
      .thr_in(thr_val[g]),
      .enable_in(en_q[2*g+1 -: 2]), // R3 R4 R5 R6 R7
      .event_out(evt[g])
    );
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      evt_q <= 12'h000;
    end else begin
      evt_q <= evt_d; // R10
    end
  end

  assign rdata_out = rdata_q;
  assign rvalid_out = rvalid_q;
  assign enable_out = en_q;
  assign event_out = evt_q;

  // ****************************************************
  // checks
  // ****************************************************
  sequence s_write_hit;
    req_in.wr && req_in.addr == tce_pkg::TCE_ENABLE_BANK4_OFFSET;
  endsequence

  sequence s_read_hit;
    req_in.rd && !req_in.wr &&
      req_in.addr == tce_pkg::TCE_ENABLE_BANK4_OFFSET;
  endsequence

  // last switch_input_twentytwo sample was not above threshold A; samples may be far apart
  logic chk_low_q;
  logic chk_low_d;

  always_comb begin
    chk_low_d = chk_low_q;
    if (switch_input_twentytwo_in.valid) begin
      chk_low_d = switch_input_twentytwo_in.value <= thr_in.group_three_threshold_a;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chk_low_q <= 1'b0;
    end else begin
      chk_low_q <= chk_low_d;
    end
  end

  sequence s_rise_in22a;
    chk_low_q && switch_input_twentytwo_in.valid &&
      switch_input_twentytwo_in.value > thr_in.group_three_threshold_a;
  endsequence

  reset_value_a: assert property ( // R1
    @(posedge clk_in) $rose(rst_n_q) |-> en_q == 24'h00_0000)
    else $error("enable register not zero after reset");

  write_store_a: assert property ( // R8
    @(posedge clk_in) disable iff (!rst_n_q)
    s_write_hit |=> en_q == $past(req_in.wdata))
    else $error("write to enable register not stored");

  read_back_a: assert property ( // R8
    @(posedge clk_in) disable iff (!rst_n_q)
    s_read_hit |=> rvalid_out && rdata_out == $past(en_q))
    else $error("read did not return register value");

  unmapped_hold_a: assert property ( // R1
    @(posedge clk_in) disable iff (!rst_n_q)
    req_in.wr && req_in.addr != tce_pkg::TCE_ENABLE_BANK4_OFFSET
    |=> $stable(en_q))
    else $error("unmapped write changed enable register");

  rise_event_a: assert property ( // R10
    @(posedge clk_in) disable iff (!rst_n_q)
    s_rise_in22a ##0 en_q[0] && $stable(thr_in)
    |=> event_out[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTWO_A])
    else $error("rising crossing with enable gave no event");

  no_enable_a: assert property ( // R2
    @(posedge clk_in) disable iff (!rst_n_q)
    en_q == 24'h00_0000 |=> event_out == 12'h000)
    else $error("event raised while all enables clear");

  rise_only_a: assert property ( // R2
    @(posedge clk_in) disable iff (!rst_n_q)
    en_q[1:0] == 2'h1 && switch_input_twentytwo_in.valid &&
      switch_input_twentytwo_in.value <= thr_in.group_three_threshold_a
    |=> !event_out[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTWO_A])
    else $error("rise-only pair fired on non-rising sample");

  event_cause_a: assert property ( // R10
    @(posedge clk_in) disable iff (!rst_n_q)
    event_out[tce_pkg::TCE_X_SUP1_B] |-> $past(supply_in.valid) &&
      $past(en_q[23:22]) != 2'h0)
    else $error("supply event without sample or enable");

  switch_input_twentythree_nine_a: assert property ( // R6
    @(posedge clk_in) disable iff (!rst_n_q)
    event_out[tce_pkg::TCE_X_SWITCH_INPUT_TWENTYTHREE_NINE] |-> $past(switch_input_twentythree_in.valid) &&
      $past(en_q[15:14]) != 2'h0)
    else $error("threshold nine event without cause");
endmodule

// >>> common/tce_pkg.sv
package tce_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [5:0] TCE_ENABLE_BANK4_OFFSET = 6'h28;
  localparam logic [23:0] TCE_ENABLE_BANK4_RESET = 24'h00_0000;
  localparam int TCE_REG_WIDTH = 24;
  localparam int TCE_SAMPLE_WIDTH = 10;
  localparam int TCE_CROSSINGS = 12;

  // ****************************************************
  // field positions (lowest bit of each field)
  // ****************************************************
  localparam int TCE_INPUT_TWENTYTWO_LSB = 0;
  localparam int TCE_INPUT_TWENTYTHREE_LSB = 6;
  localparam int TCE_SUPPLY_SET_ZERO_LSB = 16;
  localparam int TCE_SUPPLY_SET_ONE_LSB = 20;

  // ****************************************************
  // crossing indices, enable pair i sits at bits 2i+1:2i
  // ****************************************************
  localparam int TCE_X_SWITCH_INPUT_TWENTYTWO_A = 0;
  localparam int TCE_X_SWITCH_INPUT_TWENTYTWO_B = 1;
  localparam int TCE_X_SWITCH_INPUT_TWENTYTWO_C = 2;
  localparam int TCE_X_SWITCH_INPUT_TWENTYTHREE_A = 3;
  localparam int TCE_X_SWITCH_INPUT_TWENTYTHREE_B = 4;
  localparam int TCE_X_SWITCH_INPUT_TWENTYTHREE_C = 5;
  localparam int TCE_X_SWITCH_INPUT_TWENTYTHREE_EIGHT = 6;
  localparam int TCE_X_SWITCH_INPUT_TWENTYTHREE_NINE = 7;
  localparam int TCE_X_SUP0_A = 8;
  localparam int TCE_X_SUP0_B = 9;
  localparam int TCE_X_SUP1_A = 10;
  localparam int TCE_X_SUP1_B = 11;

  // ****************************************************
  // 2-bit edge code
  // ****************************************************
  typedef enum logic [1:0] {
    TCE_EDGE_NONE = 2'h0,
    TCE_EDGE_RISE = 2'h1,
    TCE_EDGE_FALL = 2'h2,
    TCE_EDGE_BOTH = 2'h3
  } tce_edge_t;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [9:0] supply_threshold_one_b;
    logic [9:0] supply_threshold_one_a;
    logic [9:0] supply_threshold_zero_b;
    logic [9:0] supply_threshold_zero_a;
    logic [9:0] group_three_threshold_c;
    logic [9:0] group_three_threshold_b;
    logic [9:0] group_three_threshold_a;
    logic [9:0] threshold_nine;
    logic [9:0] threshold_eight;
  } tce_thr_t;

  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [23:0] wdata;
  } tce_req_t;

  typedef struct packed {
    logic valid;
    logic [9:0] value;
  } tce_smp_t;
endpackage

// >>> design/tce_cross.sv
`timescale 1ns/1ps
module tce_cross #(
  parameter int W = 10
) (
  input wire logic clk_in,            // system clock
  input wire logic rst_n_in,          // synchronised reset
  input wire logic sample_valid_in,   // new sample strobe
  input wire logic [W-1:0] sample_in, // sample value
  input wire logic [W-1:0] thr_in,    // threshold
  input wire logic [1:0] enable_in,   // edge code
  output logic event_out              // crossing seen, one cycle
);
  logic above_q;
  logic above_d;
  logic seen_q;
  logic seen_d;
  logic now_above;
  logic rise;
  logic fall;

  // ****************************************************
  // compare new sample against the previous one
  // ****************************************************
  always_comb begin
    now_above = sample_in > thr_in;
    above_d = above_q;
    seen_d = seen_q;
    rise = 1'b0;
    fall = 1'b0;
    if (sample_valid_in) begin
      above_d = now_above;
      seen_d = 1'b1;
      rise = seen_q && !above_q && now_above; // R10
      fall = seen_q && above_q && !now_above; // R10
    end
    event_out = (rise && enable_in[0]) || (fall && enable_in[1]); // R2
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      above_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      above_q <= above_d;
      seen_q <= seen_d;
    end
  end
endmodule

// >>> dv/test_tce_top.sv
`timescale 1ns/1ps
module test_tce_top;
  // ****************************************************
  // stimulus and observed signals
  // ****************************************************
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  tce_pkg::tce_req_t req_in = '0;
  tce_pkg::tce_thr_t thr_in = '0;
  tce_pkg::tce_smp_t supply_in = '0;
  tce_pkg::tce_smp_t switch_input_twentytwo_in = '0;
  tce_pkg::tce_smp_t switch_input_twentythree_in = '0;
  logic [23:0] rdata_out;
  logic rvalid_out;
  logic [23:0] enable_out;
  logic [11:0] event_out;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  int g;
  logic [11:0] grp_mask [3] = '{12'h007, 12'h0f8, 12'hf00};

  tce_top u_dut (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .req_in(req_in),
    .thr_in(thr_in),
    .supply_in(supply_in),
    .switch_input_twentytwo_in(switch_input_twentytwo_in),
    .switch_input_twentythree_in(switch_input_twentythree_in),
    .rdata_out(rdata_out),
    .rvalid_out(rvalid_out),
    .enable_out(enable_out),
    .event_out(event_out)
  );

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // ****************************************************
  // compare, access and closing tasks
  // ****************************************************
  task automatic check24(input string name, input logic [23:0] exp,
                         input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check12(input string name, input logic [11:0] exp,
                         input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_in);
    #1;
    req_in = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_in);
    #1;
    req_in.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [5:0] a, input logic [23:0] exp);
    @(posedge clk_in);
    #1;
    req_in = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 24'h00_0000};
    @(posedge clk_in);
    #1;
    req_in.rd = 1'b0;
    check24("rvalid", 24'h00_0001, {23'h00_0000, rvalid_out});
    check24("rdata", exp, rdata_out);
  endtask

  // one valid sample on group 0 switch_input_twentytwo, 1 switch_input_twentythree, 2 supply
  task automatic send(input int grp, input logic [9:0] v);
    @(posedge clk_in);
    #1;
    case (grp)
      0: switch_input_twentytwo_in = {1'b1, v};
      1: switch_input_twentythree_in = {1'b1, v};
      default: supply_in = {1'b1, v};
    endcase
    @(posedge clk_in);
    #1;
    switch_input_twentytwo_in.valid = 1'b0;
    switch_input_twentythree_in.valid = 1'b0;
    supply_in.valid = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ****************************************************
  // test sequence
  // ****************************************************
  initial begin
    thr_in = {9{10'h200}};
    repeat (20) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check24("enable reset", 24'h00_0000, enable_out);
    reg_rd(6'h28, 24'h00_0000);
    reg_wr(6'h28, 24'ha5_5a3c);
    reg_rd(6'h28, 24'ha5_5a3c);
    reg_wr(6'h29, 24'hff_ffff);
    reg_rd(6'h28, 24'ha5_5a3c);
    reg_rd(6'h29, 24'h00_0000);
    reg_wr(6'h28, 24'hff_ffff);
    reg_rd(6'h28, 24'hff_ffff);
    // first sample only seeds history, then equal value is a fall
    for (int k = 0; k < 3; k++) begin
      send(k, 10'h201);
      check12("first sample", 12'h000, event_out);
      send(k, 10'h200);
      check12("fall all", grp_mask[k], event_out);
    end
    for (int i = 0; i < 12; i++) begin
      for (int c = 0; c < 4; c++) begin
        g = (i < 3) ? 0 : (i < 8) ? 1 : 2;
        reg_wr(6'h28, 24'(c) << (2 * i));
        check24("enable", 24'(c) << (2 * i), enable_out);
        send(g, 10'h201);
        check12("rise", c[0] ? 12'h001 << i : 12'h000, event_out);
        send(g, 10'h200);
        check12("fall", c[1] ? 12'h001 << i : 12'h000, event_out);
        @(posedge clk_in);
        #1;
        check12("idle", 12'h000, event_out);
      end
    end
    // reset in mid-run clears the register and the sample history
    reg_wr(6'h28, 24'hff_ffff);
    reset_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check24("enable rereset", 24'h00_0000, enable_out);
    reg_wr(6'h28, 24'hff_ffff);
    send(0, 10'h201);
    check12("first after reset", 12'h000, event_out);
    send(0, 10'h200);
    check12("fall after reset", 12'h007, event_out);
    print_verdict();
  end
endmodule
